// ### src/fcc_regs.vh
// Register map, field positions, command codes and array constants of the flash command controller
`ifndef FCC_REGS_VH
`define FCC_REGS_VH

// Register word index, taken from byte address bits [4:2]
`define FCC_IDX_DIV 3'h0
`define FCC_IDX_PROT 3'h1
`define FCC_IDX_CMD 3'h2
`define FCC_IDX_STAT 3'h3
`define FCC_IDX_LAST 3'h3

// Bus address layout
`define FCC_AW 18
`define FCC_SEL_ARRAY 17
`define FCC_RESP_OKAY 2'h0
`define FCC_RESP_SLVERR 2'h2

// Status register bit positions
`define FCC_ST_BUFFER_EMPTY_FLAG 7
`define FCC_ST_COMMAND_COMPLETE_FLAG 6
`define FCC_ST_PROTECT_VIOLATION_FLAG 5
`define FCC_ST_ACCESS_ERROR_FLAG 4
`define FCC_ST_BLANK 2

// Divider register: value field and loaded bit
`define FCC_DIV_LOADED 7
`define FCC_DIV_RST 7'h00

// Protection register fields
`define FCC_PR_OPEN 7
`define FCC_PR_HDIS 5
`define FCC_PR_HSIZE 4:3
`define FCC_PR_LDIS 2
`define FCC_PR_LSIZE 1:0
`define FCC_PROT_RST 8'hff

// Command codes
`define FCC_CMD_VERIFY 8'h05
`define FCC_CMD_PROGRAM 8'h20
`define FCC_CMD_SECTOR 8'h40
`define FCC_CMD_MASS 8'h41

// Array geometry
`define FCC_ARRAY_BYTES 17'h18000
`define FCC_WORD_LAST 16'hbfff
`define FCC_REGION_UNIT 17'h00800
`define FCC_SECTOR_MASK 17'h1fc00
`define FCC_ERASED 16'hffff
`define FCC_STRB_LO 4'h3
`define FCC_STRB_HI 4'hc

`endif

// ### src/fcc_flash_command_controller.v
// Flash command controller: AXI4-Lite registers, command sequencing and array operation control
`include "fcc_regs.vh"

module fcc_flash_command_controller (
  input wire clk,
  input wire arst_n,
  input wire [17:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [17:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire stop_req,
  input wire secure_on,
  input wire bdm_active,
  output reg arr_start,
  output reg arr_abort,
  output reg [7:0] arr_cmd,
  output reg [16:0] arr_addr,
  output reg [15:0] arr_wdata,
  output reg [15:0] arr_rd_addr,
  input wire [15:0] arr_rdata,
  input wire arr_done,
  output reg [6:0] arr_clk_div
);

  localparam SEQ_IDLE = 2'h0;
  localparam SEQ_ADDR = 2'h1;
  localparam SEQ_CMD = 2'h2;
  localparam EX_IDLE = 2'h0;
  localparam EX_WAIT = 2'h1;
  localparam EX_VERIFY = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Address lies in the protected high or low region, or the array is closed
  function is_protected;
    input [16:0] addr;
    input [7:0] prot;
    reg [16:0] hsize;
    reg [16:0] lsize;
    begin
      hsize = `FCC_REGION_UNIT << prot[`FCC_PR_HSIZE];
      lsize = `FCC_REGION_UNIT << prot[`FCC_PR_LSIZE];
      is_protected = !prot[`FCC_PR_OPEN] ||
        (!prot[`FCC_PR_HDIS] && addr >= (`FCC_ARRAY_BYTES - hsize)) ||
        (!prot[`FCC_PR_LDIS] && addr < lsize);
    end
  endfunction

  // Command code is one of the four listed
  function cmd_valid;
    input [7:0] code;
    begin
      cmd_valid = (code == `FCC_CMD_VERIFY) || (code == `FCC_CMD_PROGRAM) ||
        (code == `FCC_CMD_SECTOR) || (code == `FCC_CMD_MASS);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  reg [17:0] wa_addr;
  reg wa_nonsec;
  reg [31:0] wd_data;
  reg [3:0] wd_strb;
  reg [2:0] pin_s1;
  reg [2:0] pin_s2;
  reg stop_prev;
  reg [6:0] div_val;
  reg div_loaded;
  reg [7:0] prot;
  reg [1:0] seq;
  reg [16:0] seq_addr;
  reg [15:0] seq_data;
  reg [7:0] seq_cmd;
  reg buf_valid;
  reg [7:0] buf_cmd;
  reg [16:0] buf_addr;
  reg [15:0] buf_data;
  reg [1:0] ex;
  reg buffer_empty_flag;
  reg command_complete_flag;
  reg access_error_flag;
  reg protect_violation_flag;
  reg blank;

  wire stop_s = pin_s2[0];
  wire secure_s = pin_s2[1];
  wire bdm_s = pin_s2[2];
  wire wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_arr = wa_addr[`FCC_SEL_ARRAY];
  wire [2:0] wr_idx = wa_addr[4:2];
  wire arr_in_range = wa_addr[16:0] < `FCC_ARRAY_BYTES;
  wire wr_unmapped = wr_arr ? !arr_in_range : (wr_idx > `FCC_IDX_LAST);
  wire strb_lo = wd_strb == `FCC_STRB_LO;
  wire strb_hi = wd_strb == `FCC_STRB_HI;
  wire [16:0] word_addr = {wa_addr[16:2], strb_hi, 1'b0};
  wire [15:0] word_data = strb_hi ? wd_data[31:16] : wd_data[15:0];
  wire [7:0] wr_code = wd_data[7:0];
  wire stop_abort = stop_s && !stop_prev && (ex != EX_IDLE);
  wire op_done = (ex == EX_WAIT && arr_done) || (ex == EX_VERIFY &&
    (arr_rdata != `FCC_ERASED || arr_rd_addr == `FCC_WORD_LAST));

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and stop edge

  // Two flops per pin before any logic reads it
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      stop_prev <= 1'b0;
    end else begin
      pin_s1 <= {bdm_active, secure_on, stop_req};
      pin_s2 <= pin_s1;
      stop_prev <= stop_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write decode: sequence checking, errors, launch

  reg ev_acc;
  reg ev_pv;
  reg ev_latch;
  reg ev_cmd;
  reg ev_launch;
  reg ev_div;
  reg ev_prot;
  reg clr_acc;
  reg clr_pv;
  reg [1:0] next_seq;

  // Reads never reach this decode, so they cannot raise an error
  always @* begin
    ev_acc = 1'b0;
    ev_pv = 1'b0;
    ev_latch = 1'b0;
    ev_cmd = 1'b0;
    ev_launch = 1'b0;
    ev_div = 1'b0;
    ev_prot = 1'b0;
    clr_acc = 1'b0;
    clr_pv = 1'b0;
    next_seq = seq;
    if (wr_fire && !wr_unmapped) begin
      if (wr_arr) begin
        if (!div_loaded) begin
          ev_acc = 1'b1;
        end else if (!(strb_lo || strb_hi) || wa_addr[1:0] != 2'h0) begin
          ev_acc = 1'b1;
        end else if (!buffer_empty_flag) begin
          ev_acc = 1'b1;
        end else if (seq != SEQ_IDLE) begin
          ev_acc = 1'b1;
        end else begin
          ev_latch = 1'b1;
        end
        next_seq = ev_acc ? SEQ_IDLE : SEQ_ADDR;
      end else begin
        case (wr_idx)
          `FCC_IDX_DIV, `FCC_IDX_PROT: begin
            if (seq == SEQ_ADDR || seq == SEQ_CMD) begin
              ev_acc = 1'b1;
              next_seq = SEQ_IDLE;
            end else begin
              ev_div = wr_idx == `FCC_IDX_DIV;
              ev_prot = wr_idx == `FCC_IDX_PROT;
            end
          end
          `FCC_IDX_CMD: begin
            next_seq = SEQ_IDLE;
            if (seq != SEQ_ADDR || !cmd_valid(wr_code)) begin
              ev_acc = 1'b1;
            end else if (secure_s && (wa_nonsec || bdm_s) && wr_code != `FCC_CMD_MASS) begin
              ev_acc = 1'b1;
            end else if (wr_code == `FCC_CMD_MASS && !(prot[`FCC_PR_OPEN] &&
                prot[`FCC_PR_HDIS] && prot[`FCC_PR_LDIS])) begin
              ev_pv = 1'b1;
            end else if ((wr_code == `FCC_CMD_PROGRAM || wr_code == `FCC_CMD_SECTOR) &&
                is_protected(wr_code == `FCC_CMD_SECTOR ? (seq_addr & `FCC_SECTOR_MASK) :
                seq_addr, prot)) begin
              ev_pv = 1'b1;
            end else begin
              ev_cmd = 1'b1;
              next_seq = SEQ_CMD;
            end
          end
          default: begin
            clr_acc = wd_data[`FCC_ST_ACCESS_ERROR_FLAG];
            clr_pv = wd_data[`FCC_ST_PROTECT_VIOLATION_FLAG];
            if (seq == SEQ_ADDR) begin
              ev_acc = 1'b1;
              next_seq = SEQ_IDLE;
            end else if (seq == SEQ_CMD) begin
              if (!wd_data[`FCC_ST_BUFFER_EMPTY_FLAG]) begin
                ev_acc = 1'b1;
                next_seq = SEQ_IDLE;
              end else if (!access_error_flag && !protect_violation_flag) begin
                ev_launch = 1'b1;
                next_seq = SEQ_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration, sequence registers and error flags

  // Error flags: a set in the same cycle as a clear wins
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_val <= `FCC_DIV_RST;
      div_loaded <= 1'b0;
      prot <= `FCC_PROT_RST;
      seq <= SEQ_IDLE;
      seq_addr <= 17'h00000;
      seq_data <= 16'h0000;
      seq_cmd <= 8'h00;
      access_error_flag <= 1'b0;
      protect_violation_flag <= 1'b0;
      arr_clk_div <= `FCC_DIV_RST;
    end else begin
      seq <= next_seq;
      access_error_flag <= (access_error_flag && !clr_acc) || ev_acc || stop_abort;
      protect_violation_flag <= (protect_violation_flag && !clr_pv) || ev_pv;
      arr_clk_div <= div_val;
      if (ev_div) begin
        div_val <= wd_data[6:0];
        div_loaded <= 1'b1;
      end
      if (ev_prot) begin
        prot <= wd_data[7:0];
      end
      if (ev_latch) begin
        seq_addr <= word_addr;
        seq_data <= word_data;
      end
      if (ev_cmd) begin
        seq_cmd <= wr_code;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command buffer, active operation and completion flags

  // Buffer stage feeds the active stage once the array is free
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      buf_valid <= 1'b0;
      buf_cmd <= 8'h00;
      buf_addr <= 17'h00000;
      buf_data <= 16'h0000;
      ex <= EX_IDLE;
      buffer_empty_flag <= 1'b1;
      command_complete_flag <= 1'b1;
      blank <= 1'b0;
      arr_start <= 1'b0;
      arr_abort <= 1'b0;
      arr_cmd <= 8'h00;
      arr_addr <= 17'h00000;
      arr_wdata <= 16'h0000;
      arr_rd_addr <= 16'h0000;
    end else begin
      arr_start <= 1'b0;
      arr_abort <= 1'b0;
      if (stop_abort) begin
        ex <= EX_IDLE;
        buf_valid <= 1'b0;
        buffer_empty_flag <= 1'b1;
        command_complete_flag <= 1'b1;
        arr_abort <= 1'b1;
      end else begin
        if (op_done) begin
          ex <= EX_IDLE;
          command_complete_flag <= !buf_valid;
          if (ex == EX_VERIFY) begin
            blank <= arr_rdata == `FCC_ERASED;
          end
        end else if (ex == EX_VERIFY) begin
          arr_rd_addr <= arr_rd_addr + 16'h0001;
        end
        if (buf_valid && (ex == EX_IDLE || op_done)) begin
          buf_valid <= 1'b0;
          buffer_empty_flag <= 1'b1;
          command_complete_flag <= 1'b0;
          arr_cmd <= buf_cmd;
          arr_addr <= 17'h00000;
          arr_wdata <= 16'h0000;
          if (buf_cmd == `FCC_CMD_VERIFY) begin
            ex <= EX_VERIFY;
            blank <= 1'b0;
            arr_rd_addr <= 16'h0000;
          end else begin
            ex <= EX_WAIT;
            arr_start <= 1'b1;
            if (buf_cmd == `FCC_CMD_PROGRAM) begin
              arr_addr <= buf_addr;
              arr_wdata <= buf_data;
            end else if (buf_cmd == `FCC_CMD_SECTOR) begin
              arr_addr <= buf_addr & `FCC_SECTOR_MASK;
            end
          end
        end
        if (ev_launch) begin
          buf_valid <= 1'b1;
          buf_cmd <= seq_cmd;
          buf_addr <= seq_addr;
          buf_data <= seq_data;
          buffer_empty_flag <= 1'b0;
          command_complete_flag <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels

  // Address and data are held until both arrive, then one response
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FCC_RESP_OKAY;
      wa_addr <= 18'h00000;
      wa_nonsec <= 1'b0;
      wd_data <= 32'h00000000;
      wd_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wa_addr <= s_axi_awaddr;
        wa_nonsec <= s_axi_awprot[1];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wd_data <= s_axi_wdata;
        wd_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_unmapped ? `FCC_RESP_SLVERR : `FCC_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channels

  reg [31:0] rd_val;
  reg rd_bad;

  // Register read mux; array window reads return zero
  always @* begin
    rd_val = 32'h00000000;
    rd_bad = 1'b0;
    if (s_axi_araddr[`FCC_SEL_ARRAY]) begin
      rd_bad = !(s_axi_araddr[16:0] < `FCC_ARRAY_BYTES);
    end else begin
      case (s_axi_araddr[4:2])
        `FCC_IDX_DIV: begin
          rd_val[6:0] = div_val;
          rd_val[`FCC_DIV_LOADED] = div_loaded;
        end
        `FCC_IDX_PROT: rd_val[7:0] = prot;
        `FCC_IDX_CMD: rd_val[7:0] = seq_cmd;
        `FCC_IDX_STAT: begin
          rd_val[`FCC_ST_BUFFER_EMPTY_FLAG] = buffer_empty_flag;
          rd_val[`FCC_ST_COMMAND_COMPLETE_FLAG] = command_complete_flag;
          rd_val[`FCC_ST_PROTECT_VIOLATION_FLAG] = protect_violation_flag;
          rd_val[`FCC_ST_ACCESS_ERROR_FLAG] = access_error_flag;
          rd_val[`FCC_ST_BLANK] = blank;
        end
        default: rd_bad = 1'b1;
      endcase
    end
  end

  // One read in flight; data answers the cycle after the address is taken
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FCC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_bad ? `FCC_RESP_SLVERR : `FCC_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // fcc_flash_command_controller

// ### verification/fcc_checker_sva.sv
// Port assertions for the flash command controller
module fcc_checker (
  input wire clk,
  input wire arst_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire stop_req,
  input wire arr_start,
  input wire arr_abort,
  input wire [7:0] arr_cmd,
  input wire [16:0] arr_addr,
  input wire arr_done
);
  timeunit 1ns;
  timeprecision 1ns;
  reg busy;
  ////////////////////////////////////////////////////////////////////////////
  // Array operation in flight, from start pulse to done or abort
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) busy <= 1'b0;
    else if (arr_start) busy <= 1'b1;
    else if (arr_done || arr_abort) busy <= 1'b0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Handshake steps of the bus
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_WR_ANSWER: assert property (s_wr_taken |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write not answered in two cycles");
  AST_RD_ANSWER: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered in one cycle");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_START_CODE: assert property (arr_start |-> arr_cmd inside {8'h20, 8'h40, 8'h41})
    else $error("array started with a bad code");
  AST_SECTOR: assert property (arr_start && arr_cmd == 8'h40 |-> arr_addr[9:0] == 10'h000)
    else $error("sector address low bits not ignored");
  AST_MASS: assert property (arr_start && arr_cmd == 8'h41 |-> arr_addr == 17'h00000)
    else $error("mass erase address not zero");
  AST_ONE_OP: assert property (arr_start |-> !busy || arr_done)
    else $error("start while array busy");
  AST_ABORT: assert property (arr_abort |-> stop_req && busy)
    else $error("abort without stop during operation");
  AST_START_PULSE: assert property (arr_start |=> !arr_start)
    else $error("start longer than one cycle");
endmodule // fcc_checker

// ### verification/fcc_array_model.sv
// Behavioural array macro: timed operations and erase verify reads
module fcc_array_model (
  input wire clk,
  input wire arst_n,
  input wire arr_start,
  input wire arr_abort,
  input wire [15:0] arr_rd_addr,
  input wire slow,
  input wire [15:0] dirty_idx,
  output logic arr_done,
  output logic [15:0] arr_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left;
  // Count an operation down and pulse done at its end
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      left <= 8'h00;
      arr_done <= 1'b0;
    end else begin
      arr_done <= left == 8'h01;
      if (arr_start) left <= slow ? 8'h28 : 8'h03;
      else if (arr_abort) left <= 8'h00;
      else if (left != 8'h00) left <= left - 8'h01;
    end
  end
  // One chosen word reads as programmed, all others erased
  assign arr_rdata = arr_rd_addr == dirty_idx ? 16'h5a5a : 16'hffff;
endmodule // fcc_array_model

// ### verification/test_flash_command_controller.sv
// Self-checking bench of the flash command controller
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_flash_command_controller;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [17:0] A_DIV = 18'h00000;
  localparam logic [17:0] A_PROT = 18'h00004;
  localparam logic [17:0] A_CMD = 18'h00008;
  localparam logic [17:0] A_ST = 18'h0000c;
  localparam logic [17:0] ARR = 18'h20000;
  logic clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic stop_req, secure_on, bdm_active, arr_start, arr_abort, arr_done, slow;
  logic [7:0] arr_cmd, l_cmd;
  logic [16:0] arr_addr, l_addr;
  logic [15:0] arr_wdata, arr_rd_addr, arr_rdata, dirty_idx, l_wd;
  logic [6:0] arr_clk_div;
  int mismatches, total_checks, n_start, n_abort, cyc, n0;
  fcc_flash_command_controller fcc_flash_command_controller_i (.clk(clk), .arst_n(arst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .stop_req(stop_req), .secure_on(secure_on),
    .bdm_active(bdm_active), .arr_start(arr_start), .arr_abort(arr_abort), .arr_cmd(arr_cmd),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rd_addr(arr_rd_addr),
    .arr_rdata(arr_rdata), .arr_done(arr_done), .arr_clk_div(arr_clk_div));
  fcc_array_model fcc_array_model_i (.clk(clk), .arst_n(arst_n), .arr_start(arr_start),
    .arr_abort(arr_abort), .arr_rd_addr(arr_rd_addr), .slow(slow), .dirty_idx(dirty_idx),
    .arr_done(arr_done), .arr_rdata(arr_rdata));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, launch monitor and hang limit
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (arr_abort) n_abort++;
    if (arr_start) begin
      n_start++;
      l_cmd = arr_cmd;
      l_addr = arr_addr;
      l_wd = arr_wdata;
    end
    if (cyc == 95000) begin
      mismatches++;
      results;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks
  task automatic wr(input [17:0] a, input [31:0] v, input [3:0] s, input [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task automatic rd(input [17:0] a, output [31:0] v);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    `CHK("rresp", 2'h0, s_axi_rresp)
    s_axi_rready <= 1'b0;
  endtask
  task automatic rw(input [17:0] a, input [31:0] v);
    wr(a, v, 4'hf, 2'h0);
  endtask
  task automatic st(input [7:0] e);
    rd(A_ST, d);
    `CHK("status", e, d[7:0])
  endtask
  task automatic w0;
    wr(ARR | 18'h100, 32'h0, 4'h3, 2'h0);
  endtask
  task automatic seq(input [17:0] a, input [31:0] v, input [3:0] s, input [7:0] c);
    wr(a, v, s, 2'h0);
    rw(A_CMD, {24'h0, c});
    rw(A_ST, 32'h80);
  endtask
  task automatic wt;
    d = 32'h0;
    for (int n = 0; n < 30000 && d[6] !== 1'b1; n++) rd(A_ST, d);
    `CHK("complete", 1'b1, d[6])
  endtask
  task automatic lc(input [7:0] c, input [16:0] a, input [15:0] v);
    `CHK("cmd", c, l_cmd)
    `CHK("addr", a, l_addr)
    `CHK("wdata", v, l_wd)
  endtask
  // Error seen, launch refused while flagged, then cleared by a one
  task automatic ae;
    n0 = n_start;
    st(8'hd0);
    seq(ARR | 18'h100, 32'h0, 4'h3, 8'h20);
    repeat (4) @(posedge clk);
    `CHK("starts", n0, n_start)
    rw(A_ST, 32'h00);
    rw(A_ST, 32'h10);
    st(8'hc0);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
    {stop_req, secure_on, bdm_active, slow} = '0;
    dirty_idx = 16'hffff;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    st(8'hc0);
    rd(A_PROT, d);
    `CHK("prot", 32'hff, d)
    w0;
    ae;
    rw(A_DIV, 32'h05);
    rd(A_DIV, d);
    `CHK("div", 32'h85, d)
    `CHK("clkdiv", 7'h05, arr_clk_div)
    wr(18'h00014, 32'h0, 4'hf, 2'h2);
    wr(18'h38000, 32'h0, 4'h3, 2'h2);
    wr(ARR | 18'h100, 32'habcd, 4'h3, 2'h0);
    st(8'hc0);
    rw(A_CMD, 32'h20);
    rd(ARR, d);
    `CHK("array read", 32'h0, d)
    rw(A_ST, 32'h80);
    wt;
    lc(8'h20, 17'h00100, 16'habcd);
    st(8'hc0);
    seq(ARR | 18'h100, 32'h12340000, 4'hc, 8'h20);
    wt;
    lc(8'h20, 17'h00102, 16'h1234);
    seq(ARR | 18'h5fc, 32'h0, 4'h3, 8'h40);
    wt;
    lc(8'h40, 17'h00400, 16'h0000);
    seq(ARR | 18'h700, 32'h0, 4'h3, 8'h41);
    wt;
    lc(8'h41, 17'h00000, 16'h0000);
    slow <= 1'b1;
    n0 = n_start;
    seq(ARR | 18'h200, 32'h1, 4'h3, 8'h20);
    st(8'h80);
    seq(ARR | 18'h204, 32'h2, 4'h3, 8'h20);
    st(8'h00);
    w0;
    wt;
    `CHK("starts", n0 + 2, n_start)
    ae;
    seq(ARR | 18'h208, 32'h3, 4'h3, 8'h20);
    repeat (3) @(posedge clk);
    stop_req <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("aborts", 1, n_abort)
    stop_req <= 1'b0;
    slow <= 1'b0;
    ae;
    rw(A_PROT, 32'h7f);
    seq(ARR | 18'h300, 32'h4, 4'h3, 8'h20);
    st(8'he0);
    rw(A_PROT, 32'hff);
    n0 = n_start;
    seq(ARR | 18'h300, 32'h4, 4'h3, 8'h20);
    repeat (4) @(posedge clk);
    `CHK("starts", n0, n_start)
    rw(A_ST, 32'h30);
    rw(A_ST, 32'h10);
    rw(A_PROT, 32'h7f);
    seq(ARR | 18'h400, 32'h0, 4'h3, 8'h40);
    st(8'he0);
    rw(A_ST, 32'h20);
    rw(A_PROT, 32'hfb);
    seq(ARR | 18'h400, 32'h0, 4'h3, 8'h41);
    st(8'he0);
    rw(A_ST, 32'h20);
    rw(A_PROT, 32'hff);
    st(8'hc0);
    wr(ARR | 18'h100, 32'h0, 4'h1, 2'h0);
    ae;
    wr(ARR | 18'h101, 32'h0, 4'h3, 2'h0);
    ae;
    w0;
    w0;
    ae;
    w0;
    rw(A_DIV, 32'h05);
    ae;
    w0;
    rw(A_CMD, 32'h33);
    ae;
    w0;
    rw(A_CMD, 32'h20);
    rw(A_CMD, 32'h20);
    ae;
    w0;
    rw(A_CMD, 32'h20);
    rw(A_PROT, 32'hff);
    ae;
    w0;
    rw(A_CMD, 32'h20);
    rw(A_ST, 32'h00);
    ae;
    secure_on <= 1'b1;
    s_axi_awprot <= 3'h2;
    w0;
    rw(A_CMD, 32'h20);
    ae;
    seq(ARR, 32'h0, 4'h3, 8'h41);
    wt;
    st(8'hc0);
    s_axi_awprot <= 3'h0;
    bdm_active <= 1'b1;
    w0;
    rw(A_CMD, 32'h40);
    ae;
    {secure_on, bdm_active} <= 2'b00;
    seq(ARR, 32'h0, 4'h3, 8'h05);
    wt;
    st(8'hc4);
    dirty_idx <= 16'h0010;
    seq(ARR, 32'h0, 4'h3, 8'h05);
    wt;
    st(8'hc0);
    results;
  end
endmodule // test_flash_command_controller
bind fcc_flash_command_controller fcc_checker fcc_checker_i (.clk(clk), .arst_n(arst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .stop_req(stop_req), .arr_start(arr_start), .arr_abort(arr_abort), .arr_cmd(arr_cmd),
  .arr_addr(arr_addr), .arr_done(arr_done));
